//--- rtl/tlp_pkg.sv
// Constants and carrier types for the T1 test, loop and PRBS unit
package tlp_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CHAN = 8'h04;
    localparam logic [7:0] ADDR_DEFECT = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_ISR = 8'h10;
    localparam logic [7:0] ADDR_BEC = 8'h14;
    localparam logic [7:0] ADDR_SIMERR = 8'h18;
    // Control register bit positions
    localparam int C_GEN = 0;
    localparam int C_MON = 1;
    localparam int C_POLY20 = 2;
    localparam int C_INV = 3;
    localparam int C_FRAMED = 4;
    localparam int C_ECNT = 5;
    localparam int C_RLOOP = 6;
    localparam int C_JFIFO = 7;
    localparam int C_PLOOP = 8;
    localparam int C_TRANSP = 9;
    localparam int C_SAIS = 10;
    localparam int C_LLOOP = 11;
    localparam int C_XAIS = 12;
    localparam int C_CLOOP = 13;
    localparam int C_SIM = 14;
    localparam int CTRL_W = 15;
    // Defect request bit positions
    localparam int D_FRAME = 0;
    localparam int D_MFRAME = 1;
    localparam int D_CRC = 2;
    localparam int D_SIG = 3;
    localparam int D_PRBS = 4;
    localparam int D_BPV = 5;
    localparam logic [14:0] CTRL_RST = 15'h0000;
    localparam logic [7:0] FRAME_LAST = 8'hc0;
    localparam logic [3:0] MF_LAST = 4'hb;
    localparam logic [3:0] SIG_FRAME = 4'h5;
    localparam logic [11:0] SF_PATTERN = 12'h8dc;
    localparam logic [3:0] ZERO_MAX = 4'he;
    localparam logic [5:0] LOCK_MATCH = 6'h20;
    localparam logic [3:0] LOSE_ERRS = 4'h8;
    localparam logic [2:0] SIM_LAST = 3'h7;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tlp_apb_req_t;
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } tlp_apb_rsp_t;
    typedef struct packed {
        logic bit_tick;
        logic line_rx_inputs;
        logic system_tx_data_in;
    } tlp_stream_in_t;
endpackage : tlp_pkg

//--- rtl/tlp_unit.sv
// Test loops, PRBS, alarm simulation and defect insertion for a T1 framer
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module tlp_unit
    import tlp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire tlp_apb_req_t apb_req,
    output tlp_apb_rsp_t apb_rsp,
    input wire tlp_stream_in_t strm,
    input wire logic [3:0] real_alarms,
    input wire logic [1:0] real_slips,
    output logic line_tx_outputs,
    output logic line_tx_violation,
    output logic line_tx_clock_looped,
    output logic system_rx_data_out,
    output logic [3:0] alarm_report
);
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [4:0] chan;
        logic [7:0] idle;
        logic [5:0] defect;
        logic [2:0] alarm_sim_counter;
        logic [2:0] third_interrupt_status;
        logic [15:0] pattern_bit_error_counter;
        logic [15:0] sim_err;
        logic [7:0] pos;
        logic [3:0] frame;
        logic [19:0] gen;
        logic [3:0] gen_zeros;
        logic [19:0] mon;
        logic [5:0] match;
        logic [3:0] errs;
        logic lock;
        logic inv;
        logic [7:0] jfifo;
        logic tx_data;
        logic tx_bpv;
        logic tx_clk_loop;
        logic rx_data;
        logic [3:0] alarms;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } tlp_state_t;

    tlp_state_t st_reg;
    tlp_state_t st_next;

    // Outputs straight from the state register
    assign apb_rsp.pready = st_reg.pready;
    assign apb_rsp.prdata = st_reg.prdata;
    assign apb_rsp.pslverr = st_reg.pslverr;
    assign line_tx_outputs = st_reg.tx_data;
    assign line_tx_violation = st_reg.tx_bpv;
    assign line_tx_clock_looped = st_reg.tx_clk_loop;
    assign system_rx_data_out = st_reg.rx_data;
    assign alarm_report = st_reg.alarms;

    // All next-state logic
    always_comb begin
        logic access;
        logic done;
        logic f_bit;
        logic [7:0] pm1;
        logic [4:0] slot;
        logic [2:0] sbit;
        logic prbs_slot;
        logic rx_src;
        logic gfb;
        logic gbit;
        logic mexp;
        logic diff;
        logic b;
        logic r;
        logic in_chan;
        logic sim_on;
        logic [2:0] sc;
        st_next = st_reg;
        b = 1'b0;
        r = 1'b0;
        access = apb_req.psel & apb_req.penable & ~st_reg.pready;
        done = apb_req.psel & apb_req.penable & st_reg.pready;
        f_bit = (st_reg.pos == 8'h00);
        pm1 = st_reg.pos - 8'h01;
        slot = pm1[7:3];
        sbit = pm1[2:0];
        in_chan = st_reg.ctrl[C_CLOOP] & ~f_bit & (slot == st_reg.chan);
        prbs_slot = ~st_reg.ctrl[C_FRAMED] | ~f_bit;
        // Local loop cuts the line receiver off
        rx_src = st_reg.ctrl[C_LLOOP] ? strm.system_tx_data_in
                                      : strm.line_rx_inputs;
        gfb = st_reg.ctrl[C_POLY20] ? (st_reg.gen[19] ^ st_reg.gen[16])
                                    : (st_reg.gen[14] ^ st_reg.gen[13]);
        // Forced one breaks any run beyond the zero limit
        gbit = (st_reg.gen_zeros >= ZERO_MAX) ? 1'b1 : gfb;
        mexp = st_reg.ctrl[C_POLY20] ? (st_reg.mon[19] ^ st_reg.mon[16])
                                     : (st_reg.mon[14] ^ st_reg.mon[13]);
        diff = rx_src ^ mexp;
        sim_on = (st_reg.alarm_sim_counter != 3'h0);
        st_next.tx_bpv = 1'b0;
        st_next.ctrl[C_SIM] = 1'b0;

        // APB register file, one wait state per transfer
        st_next.pready = access;
        // Error flag stands only with its own pready
        st_next.pslverr = 1'b0;
        if (access) begin
            st_next.pslverr = 1'b0;
            st_next.prdata = 32'h0000_0000;
            case (apb_req.paddr)
                ADDR_CTRL: st_next.prdata = 32'(st_reg.ctrl);
                ADDR_CHAN: st_next.prdata = {19'h0, st_reg.idle,
                                             st_reg.chan};
                ADDR_DEFECT: st_next.prdata = 32'(st_reg.defect);
                ADDR_STAT: st_next.prdata = {25'h0, st_reg.alarm_sim_counter,
                                             st_reg.inv, st_reg.lock,
                                             2'h0};
                ADDR_ISR: st_next.prdata = 32'(st_reg.third_interrupt_status);
                ADDR_BEC: st_next.prdata =
                    32'(st_reg.pattern_bit_error_counter);
                ADDR_SIMERR: st_next.prdata = 32'(st_reg.sim_err);
                default: st_next.pslverr = 1'b1;
            endcase
        end
        if (done & apb_req.pwrite) begin
            case (apb_req.paddr)
                ADDR_CTRL: st_next.ctrl = apb_req.pwdata[CTRL_W-1:0];
                ADDR_CHAN: begin
                    st_next.chan = apb_req.pwdata[4:0];
                    st_next.idle = apb_req.pwdata[12:5];
                end
                // Requests pile up; each bit clears once spent
                ADDR_DEFECT: st_next.defect = st_reg.defect
                                              | apb_req.pwdata[5:0];
                default: ;
            endcase
        end
        // Read side effects clear sticky flags and counters
        if (done & ~apb_req.pwrite) begin
            if (apb_req.paddr == ADDR_ISR) begin
                st_next.third_interrupt_status = 3'h0;
            end
            if (apb_req.paddr == ADDR_BEC) begin
                st_next.pattern_bit_error_counter = 16'h0000;
            end
            if (apb_req.paddr == ADDR_SIMERR) begin
                st_next.sim_err = 16'h0000;
            end
        end

        // Alarm simulation stepping, wraps after eight steps
        sc = st_reg.alarm_sim_counter;
        if (st_reg.ctrl[C_SIM]) begin
            sc = (sc == SIM_LAST) ? 3'h0 : sc + 3'h1;
            st_next.alarm_sim_counter = sc;
            if (sc == 3'h5) begin
                st_next.third_interrupt_status[1] = 1'b1;
            end
            if (sc == 3'h6) begin
                st_next.third_interrupt_status[2] = 1'b1;
            end
            if (sc == 3'h6 || sc == SIM_LAST) begin
                st_next.sim_err = st_next.sim_err + 16'h0001;
            end
        end
        // Indications follow the step and so clear on their own
        if (sim_on) begin
            st_next.alarms = {sc == 3'h4, sc == 3'h3,
                              sc == 3'h2, sc == 3'h1};
        end else begin
            st_next.alarms = real_alarms;
            st_next.third_interrupt_status[2:1] =
                st_next.third_interrupt_status[2:1] | real_slips;
        end

        if (strm.bit_tick) begin
            // Frame position, F bit at 0, 12-frame superframe
            if (st_reg.pos == FRAME_LAST) begin
                st_next.pos = 8'h00;
                st_next.frame = (st_reg.frame == MF_LAST) ? 4'h0
                                : st_reg.frame + 4'h1;
            end else begin
                st_next.pos = st_reg.pos + 8'h01;
            end
            // Jitter FIFO modelled as a fixed elastic delay
            st_next.jfifo = {st_reg.jfifo[6:0], strm.line_rx_inputs};

            // Generator advances only in pattern bit positions
            if (st_reg.ctrl[C_GEN] & prbs_slot) begin
                st_next.gen = {st_reg.gen[18:0], gfb};
                st_next.gen_zeros = gbit ? 4'h0 : st_reg.gen_zeros + 4'h1;
            end

            // Self-synchronising monitor on either polarity
            if (st_reg.ctrl[C_MON] & prbs_slot) begin
                // Once locked, run on predicted bits: one error, one count
                st_next.mon = {st_reg.mon[18:0],
                               st_reg.lock ? (mexp ^ st_reg.inv)
                                           : rx_src};
                if (!st_reg.lock) begin
                    if (st_reg.match == 6'h00 || diff != st_reg.inv) begin
                        st_next.inv = diff;
                        st_next.match = 6'h01;
                    end else begin
                        st_next.match = st_reg.match + 6'h01;
                    end
                    if (st_reg.match == LOCK_MATCH) begin
                        st_next.lock = 1'b1;
                        st_next.third_interrupt_status[0] = 1'b1;
                        st_next.errs = 4'h0;
                    end
                end else if (diff != st_reg.inv) begin
                    if (st_reg.ctrl[C_ECNT] &&
                        st_reg.pattern_bit_error_counter != 16'hffff) begin
                        st_next.pattern_bit_error_counter =
                            st_next.pattern_bit_error_counter
                            + 16'h0001;
                    end
                    st_next.errs = st_reg.errs + 4'h1;
                    if (st_reg.errs == LOSE_ERRS - 4'h1) begin
                        st_next.lock = 1'b0;
                        st_next.match = 6'h00;
                        st_next.third_interrupt_status[0] = 1'b1;
                    end
                end else begin
                    st_next.errs = 4'h0;
                end
            end else if (!st_reg.ctrl[C_MON]) begin
                st_next.lock = 1'b0;
                st_next.match = 6'h00;
            end

            // Transmit bit selection
            if (st_reg.ctrl[C_PLOOP]) begin
                // System transmit inputs take no part here
                b = strm.line_rx_inputs;
                if (f_bit && !st_reg.ctrl[C_TRANSP]) begin
                    b = SF_PATTERN[MF_LAST - st_reg.frame];
                end
            end else begin
                b = strm.system_tx_data_in;
                if (f_bit) begin
                    b = SF_PATTERN[MF_LAST - st_reg.frame];
                end
                if (in_chan) begin
                    b = st_reg.idle[3'h7 - sbit];
                end
                if (st_reg.ctrl[C_GEN] & prbs_slot) begin
                    b = gbit ^ st_reg.ctrl[C_INV] ^ st_reg.defect[D_PRBS];
                    st_next.defect[D_PRBS] = 1'b0;
                end
            end
            // Single defects, each at its next opportunity
            if (f_bit && !st_reg.frame[0] && st_reg.defect[D_FRAME]) begin
                b = ~b;
                st_next.defect[D_FRAME] = 1'b0;
            end
            if (f_bit && st_reg.frame[0] && st_reg.defect[D_MFRAME]) begin
                b = ~b;
                st_next.defect[D_MFRAME] = 1'b0;
            end
            if (f_bit && st_reg.frame[1:0] == 2'h1 &&
                st_reg.defect[D_CRC]) begin
                b = ~b;
                st_next.defect[D_CRC] = 1'b0;
            end
            if (!f_bit && sbit == 3'h7 && st_reg.frame == SIG_FRAME &&
                st_reg.defect[D_SIG]) begin
                b = ~b; // Robbed bit of the signaling frame
                st_next.defect[D_SIG] = 1'b0;
            end
            if (st_reg.defect[D_BPV]) begin
                st_next.tx_bpv = 1'b1;
                st_next.defect[D_BPV] = 1'b0;
            end
            // Blue alarm to the far end, payload loop included; local and remote loopback untouched
            if (st_reg.ctrl[C_XAIS] & ~sim_on) begin
                b = 1'b1;
            end
            // Remote loop overrides every data bit toward the line; BPV requests still reach line_tx_violation
            if (st_reg.ctrl[C_RLOOP]) begin
                b = st_reg.ctrl[C_JFIFO] ? st_reg.jfifo[7]
                                         : strm.line_rx_inputs;
            end
            st_next.tx_data = b;

            // Receive toward system, still fed in remote loop
            r = rx_src;
            if (in_chan) begin
                r = strm.system_tx_data_in;
            end
            if (st_reg.ctrl[C_SAIS]) begin
                r = 1'b1;
            end
            st_next.rx_data = r;
        end
        st_next.tx_clk_loop = st_reg.ctrl[C_RLOOP];
    end

    // State register, synchronous reset
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.gen <= 20'hfffff; // Seed must be nonzero
            st_reg.ctrl <= CTRL_RST;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : tlp_unit

//--- sim/tlp_unit_monitor.sv
// Port checker for the test, loop and PRBS unit
`timescale 1ns/100ps
module tlp_unit_monitor
    import tlp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire tlp_apb_req_t apb_req,
    input wire tlp_apb_rsp_t apb_rsp,
    input wire tlp_stream_in_t strm,
    input wire logic line_tx_outputs,
    input wire logic line_tx_violation,
    input wire logic system_rx_data_out
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    property p_rdy;
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready too long");
    property p_ans;
        apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready;
    endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_own;
        apb_rsp.pready |-> apb_req.psel && apb_req.penable;
    endproperty
    a_own: assert property (p_own) else $error("pready without access");
    property p_err;
        apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_tx;
        $changed(line_tx_outputs) |-> $past(strm.bit_tick);
    endproperty
    a_tx: assert property (p_tx) else $error("tx off tick");
    property p_rx;
        $changed(system_rx_data_out) |-> $past(strm.bit_tick);
    endproperty
    a_rx: assert property (p_rx) else $error("rx off tick");
    property p_bpv;
        line_tx_violation |-> $past(strm.bit_tick) ##1 !line_tx_violation;
    endproperty
    a_bpv: assert property (p_bpv) else $error("bad violation");
    property p_req;
        apb_rsp.pready && apb_req.pwrite && apb_req.paddr == ADDR_DEFECT
            && apb_req.pwdata[D_BPV] |-> ##[1:8] line_tx_violation;
    endproperty
    a_req: assert property (p_req) else $error("no violation");
endmodule : tlp_unit_monitor

bind tlp_unit tlp_unit_monitor u_mon (.clk(clk), .srst(srst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .strm(strm),
    .line_tx_outputs(line_tx_outputs),
    .line_tx_violation(line_tx_violation),
    .system_rx_data_out(system_rx_data_out));

//--- sim/tlp_line_model.sv
// Far-end line model: loops our transmit line back or sends given bits
`timescale 1ns/100ps
module tlp_line_model (
    input wire logic line_tx,
    input wire logic loop_on,
    input wire logic corrupt,
    input wire logic send_bit,
    output logic line_rx
);
    // Corrupts a looped bit only when the bench asks for it
    always_comb begin
        line_rx = loop_on ? (line_tx ^ corrupt) : send_bit;
    end
endmodule : tlp_line_model

//--- sim/tlp_unit_tb_top.sv
// Self-checking bench for the test, loop and PRBS unit
`timescale 1ns/100ps
module tlp_unit_tb_top
    import tlp_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    tlp_apb_req_t apb_req = '0;
    tlp_apb_rsp_t apb_rsp;
    tlp_stream_in_t strm;
    logic tick = 1'b0, sys_bit = 1'b0, send_bit = 1'b0, tick_d = 1'b0;
    logic loop_on = 1'b0, corrupt = 1'b0, rl = 1'b0;
    logic rx_w, tx_o, viol, clk_lp, sys_rx;
    logic [3:0] real_alarms = 4'h0, alm = 4'h0, alarm_report;
    logic [7:0] hist = 8'h0;
    logic [7:0] idle_code = 8'h5a;
    logic [37:0] rd_q[$];
    logic [3:0] st_q[$];
    logic [31:0] lv[5] = '{32'h800, 32'h1800, 32'h440, 32'hc0, 32'h300};
    logic [31:0] d;
    int n_errors = 0, n_checks = 0, pos = 0, n_viol = 0;
    assign strm = {tick, rx_w, sys_bit};

    initial begin
        forever #12.5 clk = ~clk;
    end

    tlp_unit u_tlp_unit (.clk(clk), .srst(srst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .strm(strm), .real_alarms(real_alarms),
        .real_slips(2'b00), .line_tx_outputs(tx_o),
        .line_tx_violation(viol), .line_tx_clock_looped(clk_lp),
        .system_rx_data_out(sys_rx), .alarm_report(alarm_report));
    tlp_line_model u_tlp_line_model (.line_tx(tx_o), .loop_on(loop_on),
        .corrupt(corrupt), .send_bit(send_bit), .line_rx(rx_w));

    task automatic cmp(input logic [37:0] got, input logic [37:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // Scoreboard: oldest note against each read answer or line bit
    always @(posedge clk) begin
        logic [3:0] e;
        tick_d <= tick;
        if (viol === 1'b1)
            n_viol++;
        if (apb_rsp.pready === 1'b1 && !apb_req.pwrite && rd_q.size() > 0)
            cmp({alarm_report, clk_lp, apb_rsp.pslverr, apb_rsp.prdata},
                rd_q.pop_front());
        if (tick_d && st_q.size() > 0) begin
            e = st_q.pop_front();
            cmp(38'({tx_o & e[3], sys_rx & e[1]}),
                38'({e[2] & e[3], e[0] & e[1]}));
        end
    end

    // Request held until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] dd);
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, wr, a, dd};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do @(posedge clk); while (apb_rsp.pready !== 1'b1);
        apb_req <= '0;
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic er = 1'b0);
        rd_q.push_back({alm, rl, er, e});
        xfer(1'b0, a, 32'h0);
    endtask : rd

    // Line bits; F bit at position 0 is left unchecked where framed
    task automatic run(input int n, input int m);
        logic s, r, c, w;
        logic [3:0] e;
        for (int k = 0; k < n; k++) begin
            s = 1'($urandom);
            r = 1'($urandom);
            c = (pos != 0);
            // Looped slot gets a static system pattern, not a tone
            if (m == 6)
                s = 1'b1;
            w = c && ((pos - 1) / 8 == 3);
            case (m)
                1: e = {c, s, c, s};
                2: e = {c, 1'b1, c, s};
                3: e = {1'b1, r, 2'b11};
                4: e = {k >= 8, hist[7], c, r};
                5: e = {1'b1, r, 2'b00};
                6: e = w ? {1'b1, idle_code[7 - (pos - 1) % 8], 1'b1, s}
                         : {c, s, 1'b1, r};
                default: e = 4'h0;
            endcase
            @(posedge clk);
            tick <= 1'b1;
            sys_bit <= s;
            send_bit <= r;
            st_q.push_back(e);
            @(posedge clk);
            tick <= 1'b0;
            hist = {hist[6:0], r};
            pos = (pos + 1) % 193;
        end
    endtask : run

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // Watchdog, a few times the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h340f969c));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_STAT, 32'h0);
        rd(8'h1c, 32'h0, 1'b1);
        $display("test reset done");
        repeat (3) begin
            d = $urandom & 32'h3fff;
            rl = d[C_RLOOP];
            xfer(1'b1, ADDR_CTRL, d);
            rd(ADDR_CTRL, d);
        end
        rl = 1'b0;
        xfer(1'b1, ADDR_CTRL, 32'h0);
        $display("test regs done");
        // Local, local+alarm, remote+system alarm, remote via FIFO, payload
        foreach (lv[i]) begin
            rl = lv[i][C_RLOOP];
            xfer(1'b1, ADDR_CTRL, lv[i]);
            run(200, i + 1);
            rd(ADDR_CTRL, lv[i]);
        end
        rl = 1'b0;
        // Slot 3 looped, idle code toward the line
        xfer(1'b1, ADDR_CHAN, 32'h0000_0b43);
        xfer(1'b1, ADDR_CTRL, 32'h2000);
        run(200, 6);
        rd(ADDR_CHAN, 32'h0000_0b43);
        $display("test loops done");
        loop_on <= 1'b1;
        xfer(1'b1, ADDR_CTRL, 32'h23);
        run(100, 0);
        rd(ADDR_STAT, 32'h4);
        rd(ADDR_BEC, 32'h0);
        repeat (3) begin
            corrupt <= 1'b1;
            run(1, 0);
            corrupt <= 1'b0;
            run(20, 0);
        end
        rd(ADDR_BEC, 32'h3);
        xfer(1'b1, ADDR_CTRL, 32'h2b);
        run(80, 0);
        rd(ADDR_STAT, 32'hc);
        // Monitor off first so the new polynomial starts unlocked
        xfer(1'b1, ADDR_CTRL, 32'h25);
        run(2, 0);
        xfer(1'b1, ADDR_CTRL, 32'h27);
        run(80, 0);
        rd(ADDR_STAT, 32'h4);
        $display("test pattern done");
        loop_on <= 1'b0;
        xfer(1'b1, ADDR_CTRL, 32'h1);
        n_viol = 0;
        xfer(1'b1, ADDR_DEFECT, 32'h3f);
        run(2400, 0);
        cmp(38'(n_viol), 38'h1);
        rd(ADDR_DEFECT, 32'h0);
        $display("test defects done");
        // Second reset so no flag from earlier tests remains
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        pos = 0;
        real_alarms <= 4'hf;
        for (int k = 1; k <= 8; k++) begin
            xfer(1'b1, ADDR_CTRL, 32'h4000);
            alm = (k > 4) ? ((k == 8) ? 4'hf : 4'h0) : 4'(1 << (k - 1));
            rd(ADDR_STAT, 32'((k % 8) << 4));
            if (k == 5) begin
                rd(ADDR_ISR, 32'h2);
                rd(ADDR_ISR, 32'h0);
            end
            if (k == 7) begin
                rd(ADDR_SIMERR, 32'h2);
                rd(ADDR_SIMERR, 32'h0);
            end
        end
        $display("test simulation done");
        print_verdict();
    end
endmodule : tlp_unit_tb_top
